// ==== src/switch_cmd_regs.svh ====
// Register addresses, field positions and frame constants of the switch command decoder.
// Assumes inclusion by bare name from packages and modules that need them.
`ifndef SWITCH_CMD_REGS_SVH
`define SWITCH_CMD_REGS_SVH

// Command word layout
`define WORD_BITS          16
`define WD_BIT             15
`define ADDR_MSB           14
`define ADDR_LSB           12
`define DATA_MSB           11
`define DATA_LSB           0
`define HS_MSB             3
`define HS_LSB             0
`define LS_MSB             11
`define LS_LSB             4
`define SCALE_MSB          5
`define SCALE_LSB          4

// Register addresses
`define ADDR_OUTPUT_CMD    3'h0
`define ADDR_OPEN_LOAD     3'h1
`define ADDR_LOGIC_FUNC    3'h2
`define ADDR_UNUSED        3'h3
`define ADDR_DIRECT_EN     3'h4
`define ADDR_CURRENT_LIM   3'h5
`define ADDR_WD_SENSE      3'h6
`define ADDR_FACTORY_TEST  3'h7

// Reset values
`define RST_OUTPUT_CMD     12'h000
`define RST_DIRECT_EN      12'hfff
`define RST_LOGIC_FUNC     12'h000
`define RST_WD_SENSE       12'h000
`define RST_OPEN_LOAD      12'h000
`define RST_CURRENT_LIM    12'h000

`endif

// ==== src/switch_cmd_pkg.sv ====
// Types shared by the switch command decoder modules.
// Assumes the register header is on the include path.
package switch_cmd_pkg;
    `include "switch_cmd_regs.svh"

    // Decoded target of one command word
    typedef enum logic [2:0] {
        TGT_OUTPUT_CMD   = 3'h0,
        TGT_OPEN_LOAD    = 3'h1,
        TGT_LOGIC_FUNC   = 3'h2,
        TGT_UNUSED       = 3'h3,
        TGT_DIRECT_EN    = 3'h4,
        TGT_CURRENT_LIM  = 3'h5,
        TGT_WD_SENSE     = 3'h6,
        TGT_FACTORY_TEST = 3'h7
    } target_t;

    // Watchdog timeout divisor
    typedef enum logic [1:0] {
        WD_DIV1,
        WD_DIV2,
        WD_DIV4,
        WD_DIV8
    } wd_scale_t;
endpackage

// ==== src/frame_if.sv ====
// Interface carrying complete command words from the serial receiver to the decoder.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface frame_if;
    logic [15:0] word;      // Latest assembled word
    logic        commit;    // Pulse: frame closed with valid length
    logic        word_done; // Pulse: sixteenth bit of a word taken

    modport rx  (output word, output commit, output word_done);
    modport dec (input word, input commit, input word_done);
endinterface

// ==== src/serial_word_rx.sv ====
// Serial receiver: samples link pins, shifts bits on falling link clock edges.
// Assumes link pins already pass two flip-flops in the top module.
`timescale 1ns/1ps
module serial_word_rx
    import switch_cmd_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_sync_n,
    input  wire logic link_clk_s,
    input  wire logic sel_n_s,
    input  wire logic data_in_s,
    frame_if.rx       frame
);
    logic        link_clk_q;   // Previous synchronized link clock
    logic        sel_n_q;      // Previous synchronized select
    logic [3:0]  bit_cnt_q;    // Bits of current word, modulo sixteen
    logic [15:0] shift_q;      // Incoming word, first bit ends at top
    logic        fall;         // Falling link clock edge
    logic        rise_sel;     // Select return edge
    logic        frame_has_word_q; // At least one whole word in this frame

    assign fall     = link_clk_q & ~link_clk_s & ~sel_n_s;
    assign rise_sel = ~sel_n_q & sel_n_s;

    // Edge history
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            link_clk_q <= 1'b0;
            sel_n_q    <= 1'b1;
        end else begin
            link_clk_q <= link_clk_s;
            sel_n_q    <= sel_n_s;
        end
    end

    // Bit shifter, first bit in is most significant [R01]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shift_q <= 16'h0000;
        end else if (fall) begin
            shift_q <= {shift_q[14:0], data_in_s};
        end
    end

    // Bit counter, held clear while select is high
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_cnt_q <= 4'h0;
        end else if (sel_n_s) begin
            bit_cnt_q <= 4'h0;
        end else if (fall) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // Word and commit strobes; only whole multiples of sixteen commit [R03] [R04]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            frame.commit    <= 1'b0;
            frame.word_done <= 1'b0;
        end else begin
            frame.word_done <= fall && (bit_cnt_q == 4'hf);
            frame.commit    <= rise_sel && (bit_cnt_q == 4'h0) && frame_has_word_q;
        end
    end

    // At least one full word seen in this frame; an empty frame never commits [R04]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            frame_has_word_q <= 1'b0;
        end else if (sel_n_s) begin
            frame_has_word_q <= 1'b0;
        end else if (fall && (bit_cnt_q == 4'hf)) begin
            frame_has_word_q <= 1'b1;
        end
    end

    assign frame.word = shift_q;
endmodule

// ==== src/output_mixer.sv ====
// Combines commanded states with direct pins per output.
// Assumes direct pins already synchronized.
`timescale 1ns/1ps
module output_mixer
    import switch_cmd_pkg::*;
#(
    parameter int N = 12
) (
    input  wire logic [N-1:0] cmd,
    input  wire logic [N-1:0] direct_dis,
    input  wire logic [N-1:0] and_sel,
    input  wire logic [N-1:0] pin,
    output logic      [N-1:0] drive
);
    // Per output: AND or OR with pin when direct, else command only
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (direct_dis[i]) begin
                drive[i] = cmd[i]; // [R13]
            end else if (and_sel[i]) begin
                drive[i] = cmd[i] & pin[i]; // [R11] [R12]
            end else begin
                drive[i] = cmd[i] | pin[i]; // [R11] [R12]
            end
        end
    end
endmodule

// ==== src/spi_switch_command_decoder.sv ====
// Summary of operation
// [R01] Sixteen-bit words, most significant bit first
// [R02] Bit 15 watchdog, 14-12 address, 11-0 data
// [R03] Several whole words per frame are accepted
// [R04] Partial-length frames are discarded entirely
// [R05] Host toggles watchdog bit each word
// [R06] Three address bits select target register
// [R07] Test address writes have no effect
// [R08] Bits 3-0 high side, 11-4 low side
// [R09] One switches output on, zero off
// [R10] Zero enables direct pin control
// [R11] High side: one ANDs pin, zero ORs
// [R12] Low side: shared pin AND or OR
// [R13] Non-direct outputs follow command bit only
// [R14] Bits 5-4 divide watchdog period by 1,2,4,8
// [R15] Host toggles watchdog when changing timeout
// [R16] Sense bits route high-side currents to pairs
// [R17] High-side ones disable off-state open detection
// [R18] Low-side ones enable open-load detection
// [R19] High-side ones force sustain current limit
// [R20] Low-side ones enable overcurrent latch-off
// [R21] Registers load only at valid frame end
//
// Top of the serial command decoder for a four high, eight low side switch.
// Assumes link pins come straight from package pins, asynchronous to core_clk.
`timescale 1ns/1ps
module spi_switch_command_decoder
    import switch_cmd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        link_clk,
    input  wire logic        sel_n,
    input  wire logic        data_in,
    input  wire logic [3:0]  high_side_direct_pins,
    input  wire logic        low_side_direct_pin,
    output logic      [3:0]  high_side_outputs,
    output logic      [7:0]  low_side_outputs,
    output logic      [1:0]  sense_out_pair_a,
    output logic      [1:0]  sense_out_pair_b,
    output logic      [3:0]  high_open_detect_disable,
    output logic      [7:0]  low_open_detect_enable,
    output logic      [3:0]  sustain_limit_select,
    output logic      [7:0]  latchoff_enable_bit,
    output wd_scale_t        watchdog_scale,
    output logic             timeout_scale_hi,
    output logic             timeout_scale_lo,
    output logic             watchdog_refresh
);
    logic        rst_meta_q;     // Reset release, first stage
    logic        rst_sync_n;     // Reset release, usable copy
    logic [2:0]  clk_meta_q;     // First stage of pin synchronisers
    logic [2:0]  clk_sync_q;     // Second stage of pin synchronisers
    logic [4:0]  dir_meta_q;     // Direct pin first stage
    logic [4:0]  dir_sync_q;     // Direct pin second stage
    logic [15:0] pend_q [0:7];   // Words staged per address in this frame
    logic [7:0]  pend_v_q;       // Staged word valid per address
    logic        sel_prev_q;     // Synchronised select, one cycle back
    logic        wd_bit_q;       // Last committed watchdog bit
    logic [11:0] output_command_q;
    logic [11:0] direct_input_enable_q;
    logic [11:0] logic_function_config_q;
    logic [11:0] watchdog_sense_config_q;
    logic [11:0] open_load_config_q;
    logic [11:0] current_limit_overcurrent_config_q;
    logic [11:0] drive;          // Mixed output states
    target_t     tgt;            // Address of current word

    frame_if frame ();

    // Reset release through two flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // Link pin synchronisers; select idles high
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            clk_meta_q <= 3'h2;
            clk_sync_q <= 3'h2;
        end else begin
            clk_meta_q <= {data_in, sel_n, link_clk};
            clk_sync_q <= clk_meta_q;
        end
    end

    // Direct pin synchronisers
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dir_meta_q <= 5'h00;
            dir_sync_q <= 5'h00;
        end else begin
            dir_meta_q <= {low_side_direct_pin, high_side_direct_pins};
            dir_sync_q <= dir_meta_q;
        end
    end

    serial_word_rx u_rx (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .link_clk_s (clk_sync_q[0]),
        .sel_n_s    (clk_sync_q[1]),
        .data_in_s  (clk_sync_q[2]),
        .frame      (frame)
    );

    // Address field of the word just finished [R02] [R06]
    assign tgt = target_t'(frame.word[`ADDR_MSB:`ADDR_LSB]);

    // Stage each finished word under its address; latest word per address wins
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < 8; i++) begin
                pend_q[i] <= 16'h0000;
            end
        end else if (frame.word_done) begin
            pend_q[tgt] <= frame.word; // [R03]
        end
    end

    // Staged flags: kept until the commit reads them, dropped when a frame opens
    // or commits, so a discarded frame never reaches a register [R04]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pend_v_q   <= 8'h00;
            sel_prev_q <= 1'b1;
        end else begin
            sel_prev_q <= clk_sync_q[1];
            if ((sel_prev_q && !clk_sync_q[1]) || frame.commit) begin
                pend_v_q <= 8'h00;
            end else if (frame.word_done) begin
                pend_v_q[tgt] <= 1'b1;
            end
        end
    end

    // Output command register [R08] [R09] [R21]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            output_command_q <= `RST_OUTPUT_CMD;
        end else if (frame.commit && pend_v_q[TGT_OUTPUT_CMD]) begin
            output_command_q <= pend_q[TGT_OUTPUT_CMD][`DATA_MSB:`DATA_LSB];
        end
    end

    // Direct input enable register, ones disable direct control [R10] [R21]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            direct_input_enable_q <= `RST_DIRECT_EN;
        end else if (frame.commit && pend_v_q[TGT_DIRECT_EN]) begin
            direct_input_enable_q <= pend_q[TGT_DIRECT_EN][`DATA_MSB:`DATA_LSB];
        end
    end

    // Logic function register [R11] [R12] [R21]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            logic_function_config_q <= `RST_LOGIC_FUNC;
        end else if (frame.commit && pend_v_q[TGT_LOGIC_FUNC]) begin
            logic_function_config_q <= pend_q[TGT_LOGIC_FUNC][`DATA_MSB:`DATA_LSB];
        end
    end

    // Watchdog and sense register [R14] [R16] [R21]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            watchdog_sense_config_q <= `RST_WD_SENSE;
        end else if (frame.commit && pend_v_q[TGT_WD_SENSE]) begin
            watchdog_sense_config_q <= pend_q[TGT_WD_SENSE][`DATA_MSB:`DATA_LSB];
        end
    end

    // Open-load register [R17] [R18] [R21]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            open_load_config_q <= `RST_OPEN_LOAD;
        end else if (frame.commit && pend_v_q[TGT_OPEN_LOAD]) begin
            open_load_config_q <= pend_q[TGT_OPEN_LOAD][`DATA_MSB:`DATA_LSB];
        end
    end

    // Current limit and overcurrent register [R19] [R20] [R21]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            current_limit_overcurrent_config_q <= `RST_CURRENT_LIM;
        end else if (frame.commit && pend_v_q[TGT_CURRENT_LIM]) begin
            current_limit_overcurrent_config_q <=
                pend_q[TGT_CURRENT_LIM][`DATA_MSB:`DATA_LSB];
        end
    end
    // Unused and test addresses are staged but never copied anywhere [R07]

    // Watchdog bit of the last word in a valid frame, any address [R02] [R05]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wd_bit_q         <= 1'b0;
            watchdog_refresh <= 1'b0;
        end else begin
            watchdog_refresh <= frame.commit && (frame.word[`WD_BIT] != wd_bit_q);
            if (frame.commit) begin
                wd_bit_q <= frame.word[`WD_BIT];
            end
        end
    end

    output_mixer #(
        .N (12)
    ) u_mix (
        .cmd        (output_command_q),
        .direct_dis (direct_input_enable_q),
        .and_sel    (logic_function_config_q),
        .pin        ({{8{dir_sync_q[4]}}, dir_sync_q[3:0]}),
        .drive      (drive)
    );

    // Registered output drive, one means on [R09] [R13]
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            high_side_outputs <= 4'h0;
            low_side_outputs  <= 8'h00;
        end else begin
            high_side_outputs <= drive[`HS_MSB:`HS_LSB];
            low_side_outputs  <= drive[`LS_MSB:`LS_LSB];
        end
    end

    // Configuration fields straight from registers
    assign sense_out_pair_a         = watchdog_sense_config_q[1:0]; // [R16]
    assign sense_out_pair_b         = watchdog_sense_config_q[3:2]; // [R16]
    assign timeout_scale_hi         = watchdog_sense_config_q[`SCALE_MSB];
    assign timeout_scale_lo         = watchdog_sense_config_q[`SCALE_LSB];
    assign watchdog_scale           =
        wd_scale_t'(watchdog_sense_config_q[`SCALE_MSB:`SCALE_LSB]); // [R14]
    assign high_open_detect_disable = open_load_config_q[`HS_MSB:`HS_LSB]; // [R17]
    assign low_open_detect_enable   = open_load_config_q[`LS_MSB:`LS_LSB]; // [R18]
    assign sustain_limit_select     =
        current_limit_overcurrent_config_q[`HS_MSB:`HS_LSB]; // [R19]
    assign latchoff_enable_bit      =
        current_limit_overcurrent_config_q[`LS_MSB:`LS_LSB]; // [R20]
endmodule

// ==== tb/spi_switch_command_decoder_properties.sv ====
// Port-level checks for the serial command decoder.
// Assumes one core clock domain and the raw active-low reset.
`timescale 1ns/1ps
module spi_switch_command_decoder_properties
    import switch_cmd_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       sel_n,
    input wire logic [3:0] high_side_direct_pins,
    input wire logic       low_side_direct_pin,
    input wire logic [3:0] high_side_outputs,
    input wire logic [7:0] low_side_outputs,
    input wire logic [1:0] sense_out_pair_a,
    input wire logic [1:0] sense_out_pair_b,
    input wire logic [3:0] high_open_detect_disable,
    input wire logic [7:0] low_open_detect_enable,
    input wire logic [3:0] sustain_limit_select,
    input wire logic [7:0] latchoff_enable_bit,
    input wire wd_scale_t  watchdog_scale,
    input wire logic       timeout_scale_hi,
    input wire logic       timeout_scale_lo,
    input wire logic       watchdog_refresh
);
    // Config fields that only a closed frame may move
    wire [17:0] cfg_bits = {sustain_limit_select, latchoff_enable_bit, sense_out_pair_a,
                            sense_out_pair_b, watchdog_scale};

    // All checks on the core clock, quiet in reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_SCALE_BITS: assert property ({timeout_scale_hi, timeout_scale_lo} == watchdog_scale)
        else $error("scale bits disagree");
    AST_REFRESH_PULSE: assert property (watchdog_refresh |=> !watchdog_refresh [*3])
        else $error("refresh pulse too long");
    AST_REFRESH_AFTER_CLOSE: assert property (
        watchdog_refresh |-> $past(sel_n, 1) && $past(sel_n, 3))
        else $error("refresh without frame close");
    AST_CFG_AFTER_CLOSE: assert property (
        $changed(cfg_bits) |-> $past(sel_n, 2) && $past(sel_n, 4))
        else $error("config moved inside frame");
    AST_OPEN_HOLD: assert property (
        !sel_n [*5] |-> $stable({high_open_detect_disable, low_open_detect_enable}))
        else $error("open-load fields moved in frame");
    AST_LOW_HOLD: assert property (
        (!sel_n && $stable(low_side_direct_pin)) [*6] |-> $stable(low_side_outputs))
        else $error("low outputs moved without cause");
    AST_HIGH_HOLD: assert property (
        (!sel_n && $stable(high_side_direct_pins)) [*6] |-> $stable(high_side_outputs))
        else $error("high outputs moved without cause");
    AST_RESET_CLEAR: assert property (
        $rose(rst_n) |-> high_side_outputs == 4'h0 && low_side_outputs == 8'h00)
        else $error("outputs on after reset");

    // Main scenarios reached
    cover property (watchdog_refresh);
    cover property (watchdog_scale == WD_DIV8);
    cover property ($changed(low_side_outputs));
endmodule

bind spi_switch_command_decoder spi_switch_command_decoder_properties i_props (
    .core_clk, .rst_n, .sel_n, .high_side_direct_pins, .low_side_direct_pin,
    .high_side_outputs, .low_side_outputs, .sense_out_pair_a, .sense_out_pair_b,
    .high_open_detect_disable, .low_open_detect_enable, .sustain_limit_select,
    .latchoff_enable_bit, .watchdog_scale, .timeout_scale_hi, .timeout_scale_lo,
    .watchdog_refresh
);

// ==== tb/spi_host_model.sv ====
// Host serial master model framing command words for the decoder.
// Assumes pins change on the falling core clock edge.
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic core_clk,
    output logic      link_clk,
    output logic      sel_n,
    output logic      data_in
);
    localparam int HALF = 4; // Half of the 80 ns link period

    // Idle lines rest at their pull levels
    initial begin
        link_clk = 1'b0;
        sel_n    = 1'b1;
        data_in  = 1'b0;
    end

    // Words msb first, last cut bits dropped; lead slows the start
    task automatic frame(input logic [15:0] w[$], input int cut, input int lead);
        int n;
        n = 16 * w.size() - cut;
        @(negedge core_clk);
        sel_n = 1'b0;
        repeat (lead + 1) @(negedge core_clk); // Clock stays low across the select edge
        for (int i = 0; i < n; i++) begin
            data_in  = w[i / 16][15 - i % 16]; // Msb first
            link_clk = 1'b1;
            repeat (HALF) @(negedge core_clk);
            link_clk = 1'b0; // Bit taken on this fall
            repeat (HALF) @(negedge core_clk);
        end
        sel_n   = 1'b1; // Clock is low at both select edges
        data_in = 1'b0; // Released data falls to its pull-down
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// ==== tb/spi_switch_command_decoder_test.sv ====
// Self-checking bench for the serial command decoder.
// Assumes the host model drives the link and the checker is bound.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module spi_switch_command_decoder_test
    import switch_cmd_pkg::*;
;
    logic       core_clk = 1'b0;              // Core clock
    logic       rst_n    = 1'b0;              // Raw reset
    logic       link_clk;                     // Host link pins
    logic       sel_n;
    logic       data_in;
    logic [3:0] high_side_direct_pins = 4'h0; // Direct pins
    logic       low_side_direct_pin   = 1'b0;
    logic [3:0] high_side_outputs;            // Observed outputs
    logic [7:0] low_side_outputs;
    logic [1:0] sense_out_pair_a;
    logic [1:0] sense_out_pair_b;
    logic [3:0] high_open_detect_disable;
    logic [7:0] low_open_detect_enable;
    logic [3:0] sustain_limit_select;
    logic [7:0] latchoff_enable_bit;
    wd_scale_t  watchdog_scale;
    logic       timeout_scale_hi;
    logic       timeout_scale_lo;
    logic       watchdog_refresh;
    logic       wd = 1'b1;                    // Next watchdog bit
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         refresh_cnt = 0;
    int         exp_ref = 0;
    int         cycles = 0;

    always #5 core_clk = ~core_clk;

    spi_host_model i_host (.core_clk, .link_clk, .sel_n, .data_in);

    spi_switch_command_decoder i_dut (
        .core_clk, .rst_n, .link_clk, .sel_n, .data_in, .high_side_direct_pins,
        .low_side_direct_pin, .high_side_outputs, .low_side_outputs, .sense_out_pair_a,
        .sense_out_pair_b, .high_open_detect_disable, .low_open_detect_enable,
        .sustain_limit_select, .latchoff_enable_bit, .watchdog_scale, .timeout_scale_hi,
        .timeout_scale_lo, .watchdog_refresh
    );

    // Verdict and end of run
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Refresh pulses counted, hang cut short
    always @(posedge core_clk) begin
        cycles++;
        if (watchdog_refresh === 1'b1) refresh_cnt++;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end

    // One word frame with a fresh watchdog bit, then settle
    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        i_host.frame('{{wd, a, d}}, 0, 0);
        wd = ~wd;
        exp_ref++;
        repeat (8) @(negedge core_clk);
    endtask

    // Output image, low side above high side
    task automatic chk_out(input logic [11:0] e);
        `CHK({low_side_outputs, high_side_outputs}, e)
    endtask

    // Expected drive per output from enable, logic select, command, pin
    function automatic logic [11:0] mix(input logic [11:0] dis, lf, cmd, pin);
        return (dis & cmd) | (~dis & lf & pin & cmd) | (~dis & ~lf & (pin | cmd));
    endfunction

    initial begin
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        high_side_direct_pins = 4'hf;
        low_side_direct_pin = 1'b1;
        repeat (8) @(negedge core_clk);
        chk_out(12'h000);
        `CHK(watchdog_scale, WD_DIV1)
        // Commanded on and then off
        wr(TGT_OUTPUT_CMD, 12'ha5c);
        chk_out(12'ha5c);
        wr(TGT_OUTPUT_CMD, 12'h5a3);
        chk_out(12'h5a3);
        // Short frames of 31 and 15 bits are dropped
        i_host.frame('{{wd, TGT_OUTPUT_CMD, 12'hfff}, 16'h0000}, 1, 0);
        i_host.frame('{{wd, TGT_OUTPUT_CMD, 12'hfff}}, 1, 0);
        repeat (8) @(negedge core_clk);
        chk_out(12'h5a3);
        // Unused and test addresses, same watchdog bit
        i_host.frame('{{~wd, TGT_UNUSED, 12'hfff}, {~wd, TGT_FACTORY_TEST, 12'hfff}}, 0, 0);
        repeat (8) @(negedge core_clk);
        chk_out(12'h5a3);
        `CHK({latchoff_enable_bit, sustain_limit_select}, 12'h000)
        // Three words in one slow frame
        i_host.frame('{{~wd, TGT_OPEN_LOAD, 12'h123}, {~wd, TGT_CURRENT_LIM, 12'h456},
                       {wd, TGT_WD_SENSE, 12'h03a}}, 0, 20);
        wd = ~wd;
        exp_ref++;
        repeat (8) @(negedge core_clk);
        `CHK({low_open_detect_enable, high_open_detect_disable}, 12'h123)
        `CHK({latchoff_enable_bit, sustain_limit_select}, 12'h456)
        `CHK({sense_out_pair_b, sense_out_pair_a}, 4'ha)
        `CHK(watchdog_scale, WD_DIV8)
        // Every timeout scale, watchdog bit toggled with it
        for (int s = 0; s < 4; s++) begin
            wr(TGT_WD_SENSE, 12'(s << 4));
            `CHK({timeout_scale_hi, timeout_scale_lo}, 2'(s))
            `CHK(watchdog_scale, wd_scale_t'(s))
        end
        // Mixed direct and commanded control over pin patterns
        wr(TGT_LOGIC_FUNC, 12'h0f3);
        wr(TGT_DIRECT_EN, 12'h0c2);
        for (int p = 0; p < 32; p += 5) begin
            high_side_direct_pins = p[3:0];
            low_side_direct_pin = p[4];
            repeat (8) @(negedge core_clk);
            chk_out(mix(12'h0c2, 12'h0f3, 12'h5a3, {{8{p[4]}}, p[3:0]}));
        end
        `CHK(refresh_cnt, exp_ref)
        results();
    end
endmodule
